// ---- core/opcode_decoder_pkg.sv ----
// Package with instruction field layout, operation enumeration and reset values for the opcode decoder.
package opcode_decoder_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int INSTR_W = 12;
  localparam int PC_W = 10;
  localparam logic [9:0] PC_RESET = 10'h000;
  localparam logic [9:0] PC_STEP = 10'h001;
  localparam logic [9:0] PC_CALL_STEP = 10'h002;

  // ****************************************************************
  // Field positions and fixed codes
  // ****************************************************************
  localparam int GRP_HI = 11;
  localparam int GRP_LO = 8;
  localparam int MID_HI = 7;
  localparam int MID_LO = 4;
  localparam logic [11:0] CODE_NOP = 12'h000;
  localparam logic [11:0] CODE_HALT_IMM = 12'h111;
  localparam logic [11:0] CODE_STATUS_IMM = 12'h131;
  localparam logic [11:0] CODE_SET_CARRY = 12'hD13;
  localparam logic [11:0] CODE_INC_ACC = 12'hA13;
  localparam logic [11:0] CODE_ROT_ACC = 12'hF13;
  localparam logic [11:0] CODE_CALL_FIRST = 12'h312;
  localparam logic [11:0] CODE_JUMP_DIRECT = 12'h411;
  localparam logic [11:0] CODE_RETURN = 12'h412;
  localparam logic [11:0] CODE_TIMER_IMM = 12'h31F;
  localparam logic [11:0] CODE_TIMER_IND = 12'h33F;

  // ****************************************************************
  // Operation classes
  // ****************************************************************
  typedef enum logic [2:0] {
    ALU_NONE, ALU_AND, ALU_OR, ALU_XOR, ALU_LOAD
  } alu_op_t;

  typedef enum logic [2:0] {
    SRC_NONE, SRC_REG, SRC_IND, SRC_IMM, SRC_PORT, SRC_TIMER
  } src_t;

  typedef enum logic [4:0] {
    OP_NOP, OP_ALU, OP_ACC_TO_REG, OP_ACC_TO_PORT, OP_PORT_IMM, OP_PAIR_IMM, OP_PAIR_IND,
    OP_ACC_TO_TIMER, OP_TIMER_IMM, OP_TIMER_IND, OP_JUMP, OP_CALL, OP_RETURN,
    OP_STATUS_REG, OP_STATUS_IMM, OP_SET_CARRY, OP_HALT, OP_INC_ACC, OP_ROT_ACC
  } op_t;

  typedef enum logic [2:0] {
    COND_ALWAYS, COND_CARRY, COND_NO_CARRY, COND_FLAG, COND_NO_FLAG
  } cond_t;

endpackage

// ---- core/ir_remote_mcu_opcode_decoder.sv ----
// Instruction decoder of the 4-bit remote-control controller, with its program counter sequencing.
`timescale 1ns/100ps

// Behaviour
// - D0x/D2x and-with-register, D10/D30 indirect, D31 immediate.
// - E0x/E2x or-with-register, E10/E30 indirect, E31 immediate.
// - A0x/A2x xor-with-register, A10/A30 indirect, A31 immediate.
// - F18-F1A read high port halves, F38-F3A low halves.
// - 218-21A write high port halves, 238-23A low halves.
// - D/E/A 18-1A and 38-3A combine port with accumulator.
// - 318-31A write immediate to whole port pair.
// - F0x/F2x register to accumulator, F10/F30 indirect, F31 immediate.
// - 20x/22x move accumulator to upper/lower register.
// - 30r loads pair immediate, 32r loads pair through indirect register.
// - 312 then 411 is a call; 412 returns.
// - F1F/F3F read timer parts, 21F/23F write them.
// - 31F loads timer immediate, 33F loads timer through indirect register.
// - 12r sets status from lower register, 131 immediate.
// - D13 sets carry, 000 no operation, 111 standby.
// - Rotate left without serial input copies MSB into LSB.
module ir_remote_mcu_opcode_decoder (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [11:0] instr,
  input wire logic instr_valid,
  input wire logic [11:0] next_word,
  input wire logic carry_in,
  input wire logic flag_in,
  input wire logic serial_sel,
  input wire logic [9:0] pair_target,
  input wire logic [9:0] return_addr,
  output logic [9:0] pc,
  output logic [9:0] call_return_addr,
  output logic op_valid,
  output opcode_decoder_pkg::op_t op,
  output opcode_decoder_pkg::alu_op_t alu_op,
  output opcode_decoder_pkg::src_t src,
  output logic [4:0] reg_sel,
  output logic [1:0] port_sel,
  output logic port_high,
  output logic timer_high,
  output logic [3:0] pair_sel,
  output logic rot_msb_to_lsb,
  output logic branch_taken,
  output logic illegal_code
);

  // ****************************************************************
  // Decode combinational logic
  // ****************************************************************

  opcode_decoder_pkg::op_t op_next;
  opcode_decoder_pkg::alu_op_t alu_next;
  opcode_decoder_pkg::src_t src_next;
  opcode_decoder_pkg::cond_t cond_next;
  logic [4:0] reg_next;
  logic [1:0] port_next;
  logic port_high_next;
  logic timer_high_next;
  logic [3:0] pair_next;
  logic known_next;
  logic [3:0] grp;
  logic [3:0] mid;
  logic [3:0] low;

  assign grp = instr[opcode_decoder_pkg::GRP_HI:opcode_decoder_pkg::GRP_LO];
  assign mid = instr[opcode_decoder_pkg::MID_HI:opcode_decoder_pkg::MID_LO];
  assign low = instr[3:0];

  // Maps the leading digit of a logic or load group to its ALU operation.
  function automatic opcode_decoder_pkg::alu_op_t alu_of(input logic [3:0] g);
    unique case (g)
      4'hD: alu_of = opcode_decoder_pkg::ALU_AND;
      4'hE: alu_of = opcode_decoder_pkg::ALU_OR;
      4'hA: alu_of = opcode_decoder_pkg::ALU_XOR;
      4'hF: alu_of = opcode_decoder_pkg::ALU_LOAD;
      default: alu_of = opcode_decoder_pkg::ALU_NONE;
    endcase
  endfunction

  // True for a valid port index 8 to A in the low digit.
  function automatic logic is_port(input logic [3:0] l);
    is_port = (l >= 4'h8) && (l <= 4'hA);
  endfunction

  // Every field except pair_next, which takes the low digit, defaults to an inert value so unlisted codes leave the datapath alone.
  always_comb begin
    op_next = opcode_decoder_pkg::OP_NOP;
    alu_next = opcode_decoder_pkg::ALU_NONE;
    src_next = opcode_decoder_pkg::SRC_NONE;
    cond_next = opcode_decoder_pkg::COND_ALWAYS;
    reg_next = 5'h00;
    port_next = 2'h0;
    port_high_next = 1'b0;
    timer_high_next = 1'b0;
    pair_next = low;
    known_next = 1'b1;
    if (instr == opcode_decoder_pkg::CODE_NOP) begin
      op_next = opcode_decoder_pkg::OP_NOP;
    end else if (instr == opcode_decoder_pkg::CODE_HALT_IMM) begin
      op_next = opcode_decoder_pkg::OP_HALT;
    end else if (instr == opcode_decoder_pkg::CODE_SET_CARRY) begin
      op_next = opcode_decoder_pkg::OP_SET_CARRY;
    end else if (instr == opcode_decoder_pkg::CODE_INC_ACC) begin
      op_next = opcode_decoder_pkg::OP_INC_ACC;
    end else if (instr == opcode_decoder_pkg::CODE_ROT_ACC) begin
      op_next = opcode_decoder_pkg::OP_ROT_ACC;
    end else if (instr == opcode_decoder_pkg::CODE_STATUS_IMM) begin
      op_next = opcode_decoder_pkg::OP_STATUS_IMM;
      src_next = opcode_decoder_pkg::SRC_IMM;
    end else if (grp == 4'h1 && mid == 4'h2) begin
      op_next = opcode_decoder_pkg::OP_STATUS_REG;
      src_next = opcode_decoder_pkg::SRC_REG;
      reg_next = {1'b0, low};
    end else if (instr == opcode_decoder_pkg::CODE_CALL_FIRST) begin
      op_next = opcode_decoder_pkg::OP_CALL;
    end else if (instr == opcode_decoder_pkg::CODE_RETURN) begin
      op_next = opcode_decoder_pkg::OP_RETURN;
    end else if (instr == opcode_decoder_pkg::CODE_TIMER_IMM) begin
      op_next = opcode_decoder_pkg::OP_TIMER_IMM;
      src_next = opcode_decoder_pkg::SRC_IMM;
    end else if (instr == opcode_decoder_pkg::CODE_TIMER_IND) begin
      op_next = opcode_decoder_pkg::OP_TIMER_IND;
      src_next = opcode_decoder_pkg::SRC_IND;
    end else if ((grp == 4'h4 || grp == 4'h6 || grp == 4'h7) && (mid == 4'h1 || mid == 4'h3) && low == 4'h1
                 && !(grp == 4'h4 && mid == 4'h3)) begin
      op_next = opcode_decoder_pkg::OP_JUMP;
      src_next = opcode_decoder_pkg::SRC_IMM;
      cond_next = (grp == 4'h4) ? opcode_decoder_pkg::COND_ALWAYS :
                  (grp == 4'h6) ? ((mid == 4'h1) ? opcode_decoder_pkg::COND_CARRY : opcode_decoder_pkg::COND_NO_CARRY) :
                  ((mid == 4'h1) ? opcode_decoder_pkg::COND_FLAG : opcode_decoder_pkg::COND_NO_FLAG);
    // pair zero is never encoded, so it is rejected here
    end else if ((grp == 4'h4 || grp == 4'h6 || grp == 4'h7) && (mid == 4'h0 || mid == 4'h2) && low != 4'h0
                 && !(grp == 4'h4 && mid == 4'h2)) begin
      op_next = opcode_decoder_pkg::OP_JUMP;
      src_next = opcode_decoder_pkg::SRC_REG;
      cond_next = (grp == 4'h4) ? opcode_decoder_pkg::COND_ALWAYS :
                  (grp == 4'h6) ? ((mid == 4'h0) ? opcode_decoder_pkg::COND_CARRY : opcode_decoder_pkg::COND_NO_CARRY) :
                  ((mid == 4'h0) ? opcode_decoder_pkg::COND_FLAG : opcode_decoder_pkg::COND_NO_FLAG);
    end else if (grp == 4'h3 && mid == 4'h1 && is_port(low)) begin
      op_next = opcode_decoder_pkg::OP_PORT_IMM;
      src_next = opcode_decoder_pkg::SRC_IMM;
      port_next = 2'(low - 4'h8);
    end else if (grp == 4'h3 && (mid == 4'h0 || mid == 4'h2)) begin
      op_next = (mid == 4'h0) ? opcode_decoder_pkg::OP_PAIR_IMM : opcode_decoder_pkg::OP_PAIR_IND;
      src_next = (mid == 4'h0) ? opcode_decoder_pkg::SRC_IMM : opcode_decoder_pkg::SRC_IND;
    end else if (grp == 4'h2 && (mid == 4'h1 || mid == 4'h3) && low == 4'hF) begin
      op_next = opcode_decoder_pkg::OP_ACC_TO_TIMER;
      timer_high_next = (mid == 4'h1);
    end else if (grp == 4'h2 && (mid == 4'h1 || mid == 4'h3) && is_port(low)) begin
      op_next = opcode_decoder_pkg::OP_ACC_TO_PORT;
      port_next = 2'(low - 4'h8);
      port_high_next = (mid == 4'h1);
    end else if (grp == 4'h2 && (mid == 4'h0 || mid == 4'h2)) begin
      op_next = opcode_decoder_pkg::OP_ACC_TO_REG;
      reg_next = {(mid == 4'h0), low};
    end else if (alu_of(grp) != opcode_decoder_pkg::ALU_NONE) begin
      op_next = opcode_decoder_pkg::OP_ALU;
      alu_next = alu_of(grp);
      if (mid == 4'h0 || mid == 4'h2) begin
        src_next = opcode_decoder_pkg::SRC_REG;
        reg_next = {(mid == 4'h0), low};
      end else if ((mid == 4'h1 || mid == 4'h3) && low == 4'h0) begin
        src_next = opcode_decoder_pkg::SRC_IND;
        port_high_next = (mid == 4'h1);
      end else if (mid == 4'h3 && low == 4'h1) begin
        src_next = opcode_decoder_pkg::SRC_IMM;
      end else if ((mid == 4'h1 || mid == 4'h3) && is_port(low)) begin
        src_next = opcode_decoder_pkg::SRC_PORT;
        port_next = 2'(low - 4'h8);
        port_high_next = (mid == 4'h1);
      end else if (grp == 4'hF && (mid == 4'h1 || mid == 4'h3) && low == 4'hF) begin
        src_next = opcode_decoder_pkg::SRC_TIMER;
        timer_high_next = (mid == 4'h1);
      end else begin
        op_next = opcode_decoder_pkg::OP_NOP;
        alu_next = opcode_decoder_pkg::ALU_NONE;
        known_next = 1'b0;
      end
    end else begin
      known_next = 1'b0;
    end
  end

  logic cond_met;
  always_comb begin
    unique case (cond_next)
      opcode_decoder_pkg::COND_ALWAYS: cond_met = 1'b1;
      opcode_decoder_pkg::COND_CARRY: cond_met = carry_in;
      opcode_decoder_pkg::COND_NO_CARRY: cond_met = !carry_in;
      opcode_decoder_pkg::COND_FLAG: cond_met = flag_in;
      default: cond_met = !flag_in;
    endcase
  end

  // ****************************************************************
  // Registered decode outputs
  // ****************************************************************

  // Decoded fields are held one cycle so the datapath sees flip-flop outputs.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      op_valid <= 1'b0;
      op <= opcode_decoder_pkg::OP_NOP;
      alu_op <= opcode_decoder_pkg::ALU_NONE;
      src <= opcode_decoder_pkg::SRC_NONE;
      reg_sel <= 5'h00;
      port_sel <= 2'h0;
      port_high <= 1'b0;
      timer_high <= 1'b0;
      pair_sel <= 4'h0;
      rot_msb_to_lsb <= 1'b0;
      branch_taken <= 1'b0;
      illegal_code <= 1'b0;
    end else begin
      op_valid <= instr_valid;
      op <= instr_valid ? op_next : opcode_decoder_pkg::OP_NOP;
      alu_op <= instr_valid ? alu_next : opcode_decoder_pkg::ALU_NONE;
      src <= src_next;
      reg_sel <= reg_next;
      port_sel <= port_next;
      port_high <= port_high_next;
      timer_high <= timer_high_next;
      pair_sel <= pair_next;
      // rotate feeds MSB back when serial input is off
      rot_msb_to_lsb <= instr_valid && (op_next == opcode_decoder_pkg::OP_ROT_ACC) && !serial_sel;
      branch_taken <= instr_valid && (op_next == opcode_decoder_pkg::OP_JUMP) && cond_met;
      illegal_code <= instr_valid && !known_next;
    end
  end

  // ****************************************************************
  // Program counter
  // ****************************************************************

  logic [9:0] pc_next;
  logic call_ok;
  assign call_ok = (next_word == opcode_decoder_pkg::CODE_JUMP_DIRECT);

  // A call not followed by its jump word is treated as a plain step, never a branch.
  always_comb begin
    pc_next = pc;
    if (instr_valid) begin
      pc_next = pc + opcode_decoder_pkg::PC_STEP;
      if (op_next == opcode_decoder_pkg::OP_JUMP && cond_met) begin
        pc_next = pair_target;
      end else if (op_next == opcode_decoder_pkg::OP_RETURN) begin
        pc_next = return_addr;
      end else if (op_next == opcode_decoder_pkg::OP_CALL && call_ok) begin
        pc_next = pair_target;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pc <= opcode_decoder_pkg::PC_RESET;
      call_return_addr <= opcode_decoder_pkg::PC_RESET;
    end else begin
      pc <= pc_next;
      if (instr_valid && op_next == opcode_decoder_pkg::OP_CALL && call_ok) begin
        call_return_addr <= pc + opcode_decoder_pkg::PC_CALL_STEP;
      end
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************

  sequence nop_in_s;
    instr_valid && instr == opcode_decoder_pkg::CODE_NOP;
  endsequence

  nop_decode_a: assert property (@(posedge clk) disable iff (sys_rst)
    nop_in_s |=> op == opcode_decoder_pkg::OP_NOP && !illegal_code)
    else $error("No-operation code decoded wrongly.");

  and_reg_a: assert property (@(posedge clk) disable iff (sys_rst)
    instr_valid && instr[11:4] == 8'hD2 |=> alu_op == opcode_decoder_pkg::ALU_AND && src == opcode_decoder_pkg::SRC_REG
      && !reg_sel[4])
    else $error("Lower bank and-with-register decoded wrongly.");

  or_imm_a: assert property (@(posedge clk) disable iff (sys_rst)
    instr_valid && instr == 12'hE31 |=> alu_op == opcode_decoder_pkg::ALU_OR && src == opcode_decoder_pkg::SRC_IMM)
    else $error("Or immediate decoded wrongly.");

  xor_port_a: assert property (@(posedge clk) disable iff (sys_rst)
    instr_valid && instr == 12'hA39 |=> alu_op == opcode_decoder_pkg::ALU_XOR && src == opcode_decoder_pkg::SRC_PORT
      && port_sel == 2'h1 && !port_high)
    else $error("Xor with port decoded wrongly.");

  port_out_a: assert property (@(posedge clk) disable iff (sys_rst)
    instr_valid && instr == 12'h21A |=> op == opcode_decoder_pkg::OP_ACC_TO_PORT && port_sel == 2'h2 && port_high)
    else $error("Port output decoded wrongly.");

  pair_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
    instr_valid && instr == 12'h600 |=> illegal_code && !branch_taken)
    else $error("Branch on pair zero was accepted.");

  carry_jump_a: assert property (@(posedge clk) disable iff (sys_rst)
    instr_valid && instr == 12'h611 && carry_in |=> branch_taken && pc == $past(pair_target))
    else $error("Jump on carry did not branch.");

  rot_acc_a: assert property (@(posedge clk) disable iff (sys_rst)
    instr_valid && instr == opcode_decoder_pkg::CODE_ROT_ACC |=> rot_msb_to_lsb == !$past(serial_sel))
    else $error("Rotate feedback selection wrong.");

  pc_step_a: assert property (@(posedge clk) disable iff (sys_rst)
    nop_in_s |=> pc == 10'($past(pc) + 10'h001))
    else $error("Counter did not advance by one.");

  unknown_code_a: assert property (@(posedge clk) disable iff (sys_rst)
    instr_valid && instr == 12'hB00 |=> op == opcode_decoder_pkg::OP_NOP && illegal_code)
    else $error("Unlisted code was not a no-operation.");
endmodule

// ---- testbench/program_memory_model.sv ----
// Program memory model that hands the decoder the word at pc and the word after it.
`timescale 1ns/100ps
module program_memory_model (
  input wire logic [9:0] pc,
  output logic [11:0] instr,
  output logic [11:0] next_word
);
  logic [11:0] mem [0:1024];

  // The read is combinational, so a word planted before an edge is what that edge samples.
  // pair code
  // Branch words carry pair 1 to F unless a scenario plants pair 0 on purpose.
  assign instr = mem[pc];
  assign next_word = mem[{1'b0, pc} + 11'h001];

  // Every word starts as a no-operation so a stray fetch has no effect.
  initial begin
    for (int i = 0; i < 1025; i++) begin
      mem[i] = 12'h000;
    end
  end

  task automatic put(input logic [10:0] addr, input logic [11:0] word);
    mem[addr] = word;
  endtask
endmodule

// ---- testbench/ir_remote_mcu_opcode_decoder_tb.sv ----
// Self-checking bench for the opcode decoder fed from a program memory model.
`timescale 1ns/100ps
module ir_remote_mcu_opcode_decoder_tb;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic instr_valid = 1'b0;
  logic carry_in = 1'b0;
  logic flag_in = 1'b0;
  logic serial_sel = 1'b0;
  logic [9:0] pair_target = 10'h155;
  logic [9:0] return_addr = 10'h2AA;
  logic [11:0] nxt_w = 12'h000;
  logic [11:0] instr;
  logic [11:0] next_word;
  logic [9:0] pc;
  logic [9:0] call_return_addr;
  logic op_valid;
  opcode_decoder_pkg::op_t op;
  opcode_decoder_pkg::alu_op_t alu_op;
  opcode_decoder_pkg::src_t src;
  logic [4:0] reg_sel;
  logic [1:0] port_sel;
  logic port_high;
  logic timer_high;
  logic [3:0] pair_sel;
  logic rot_msb_to_lsb;
  logic branch_taken;
  logic illegal_code;
  logic [9:0] exp_pc = 10'h000;
  int fails = 0;
  int check_count = 0;

  // Free-running 10 MHz clock.
  always #50 clk = ~clk;

  ir_remote_mcu_opcode_decoder DUT (
    .clk(clk), .sys_rst(sys_rst), .instr(instr), .instr_valid(instr_valid), .next_word(next_word),
    .carry_in(carry_in), .flag_in(flag_in), .serial_sel(serial_sel), .pair_target(pair_target),
    .return_addr(return_addr), .pc(pc), .call_return_addr(call_return_addr), .op_valid(op_valid),
    .op(op), .alu_op(alu_op), .src(src), .reg_sel(reg_sel), .port_sel(port_sel), .port_high(port_high),
    .timer_high(timer_high), .pair_sel(pair_sel), .rot_msb_to_lsb(rot_msb_to_lsb),
    .branch_taken(branch_taken), .illegal_code(illegal_code)
  );

  program_memory_model pmem (.pc(pc), .instr(instr), .next_word(next_word));

  // *****************************
  // Helpers
  // *****************************
  task automatic chk(input string name, input logic [11:0] seen, input logic [11:0] want);
    check_count++;
    if (seen !== want) begin
      fails++;
      $display("Error %s expected %h seen %h", name, want, seen);
    end
  endtask

  // Plants a word at the expected pc and lets one edge take it; valid stays up for back-to-back use.
  task automatic issue(input logic [11:0] code);
    pmem.put({1'b0, exp_pc}, code);
    pmem.put({1'b0, exp_pc} + 11'h001, nxt_w);
    instr_valid = 1'b1;
    @(posedge clk);
    @(negedge clk);
  endtask

  task automatic exec(input logic [11:0] code, input opcode_decoder_pkg::op_t eop, input logic jump);
    logic [9:0] want_pc;
    want_pc = jump ? pair_target : exp_pc + 10'h001;
    issue(code);
    chk("op", 12'(op), 12'(eop));
    chk("op_valid", 12'(op_valid), 12'h001);
    chk("pc", 12'(pc), 12'(want_pc));
    chk("branch_taken", 12'(branch_taken), 12'(jump));
    chk("illegal_code", 12'(illegal_code), 12'(eop == opcode_decoder_pkg::OP_NOP && code != 12'h000));
    exp_pc = want_pc;
  endtask

  task automatic port_chk(input int p, input int h);
    chk("port_sel", 12'(port_sel), 12'(p));
    chk("port_high", 12'(port_high), 12'(h));
  endtask

  // An idle cycle between tests; the counter must hold while nothing is valid.
  task automatic done_test(input string name);
    instr_valid = 1'b0;
    @(negedge clk);
    chk("pc", 12'(pc), 12'(exp_pc));
    $display("Test %s finished, %0d mismatches so far", name, fails);
  endtask

  task automatic give_verdict;
    $display("Checks %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // *****************************
  // Scenarios
  // *****************************
  task automatic t_alu;
    logic [3:0] grp [4] = '{4'hD, 4'hE, 4'hA, 4'hF};
    for (int g = 0; g < 4; g++) begin
      exec({grp[g], 8'h07}, opcode_decoder_pkg::OP_ALU, 1'b0);
      chk("alu_op", 12'(alu_op), 12'(g + 1));
      chk("src", 12'(src), 12'(opcode_decoder_pkg::SRC_REG));
      chk("reg_sel", 12'(reg_sel), 12'h017);
      exec({grp[g], 8'h2C}, opcode_decoder_pkg::OP_ALU, 1'b0);
      chk("reg_sel", 12'(reg_sel), 12'h00C);
      exec({grp[g], 8'h10}, opcode_decoder_pkg::OP_ALU, 1'b0);
      chk("src", 12'(src), 12'(opcode_decoder_pkg::SRC_IND));
      chk("port_high", 12'(port_high), 12'h001);
      exec({grp[g], 8'h30}, opcode_decoder_pkg::OP_ALU, 1'b0);
      chk("port_high", 12'(port_high), 12'h000);
      exec({grp[g], 8'h31}, opcode_decoder_pkg::OP_ALU, 1'b0);
      chk("src", 12'(src), 12'(opcode_decoder_pkg::SRC_IMM));
      chk("alu_op", 12'(alu_op), 12'(g + 1));
    end
    done_test("alu");
  endtask

  task automatic t_port;
    logic [7:0] lo;
    logic [3:0] grp [3] = '{4'hD, 4'hE, 4'hA};
    for (int p = 0; p < 3; p++) begin
      for (int h = 0; h < 2; h++) begin
        lo = (h == 1 ? 8'h18 : 8'h38) + 8'(p);
        exec({4'hF, lo}, opcode_decoder_pkg::OP_ALU, 1'b0);
        chk("src", 12'(src), 12'(opcode_decoder_pkg::SRC_PORT));
        port_chk(p, h);
        exec({4'h2, lo}, opcode_decoder_pkg::OP_ACC_TO_PORT, 1'b0);
        port_chk(p, h);
        for (int g = 0; g < 3; g++) begin
          exec({grp[g], lo}, opcode_decoder_pkg::OP_ALU, 1'b0);
          chk("alu_op", 12'(alu_op), 12'(g + 1));
          port_chk(p, h);
        end
      end
      exec(12'h318 + 12'(p), opcode_decoder_pkg::OP_PORT_IMM, 1'b0);
      chk("port_sel", 12'(port_sel), 12'(p));
    end
    done_test("port");
  endtask

  task automatic t_move;
    for (int r = 0; r < 16; r += 15) begin
      exec(12'h200 + 12'(r), opcode_decoder_pkg::OP_ACC_TO_REG, 1'b0);
      chk("reg_sel", 12'(reg_sel), 12'h010 + 12'(r));
      exec(12'h220 + 12'(r), opcode_decoder_pkg::OP_ACC_TO_REG, 1'b0);
      chk("reg_sel", 12'(reg_sel), 12'(r));
      exec(12'h300 + 12'(r), opcode_decoder_pkg::OP_PAIR_IMM, 1'b0);
      chk("pair_sel", 12'(pair_sel), 12'(r));
      exec(12'h320 + 12'(r), opcode_decoder_pkg::OP_PAIR_IND, 1'b0);
      chk("pair_sel", 12'(pair_sel), 12'(r));
    end
    done_test("move");
  endtask

  // Every carry and flag condition is tried both ways, and the pair-0 forms must be refused.
  task automatic t_branch;
    logic [11:0] bad [5] = '{12'h400, 12'h600, 12'h620, 12'h700, 12'h720};
    exec(12'h411, opcode_decoder_pkg::OP_JUMP, 1'b1);
    exec(12'h40A, opcode_decoder_pkg::OP_JUMP, 1'b1);
    for (int c = 0; c < 2; c++) begin
      carry_in = c[0];
      flag_in = !c[0];
      pair_target = c[0] ? 10'h155 : 10'h2A0;
      exec(12'h611, opcode_decoder_pkg::OP_JUMP, c[0]);
      exec(12'h60F, opcode_decoder_pkg::OP_JUMP, c[0]);
      exec(12'h631, opcode_decoder_pkg::OP_JUMP, !c[0]);
      exec(12'h621, opcode_decoder_pkg::OP_JUMP, !c[0]);
      exec(12'h711, opcode_decoder_pkg::OP_JUMP, !c[0]);
      exec(12'h702, opcode_decoder_pkg::OP_JUMP, !c[0]);
      exec(12'h731, opcode_decoder_pkg::OP_JUMP, c[0]);
      exec(12'h72F, opcode_decoder_pkg::OP_JUMP, c[0]);
    end
    for (int i = 0; i < 5; i++) begin
      exec(bad[i], opcode_decoder_pkg::OP_NOP, 1'b0);
    end
    done_test("branch");
  endtask

  task automatic t_call;
    logic [9:0] base;
    base = exp_pc;
    nxt_w = 12'h411;
    issue(12'h312);
    nxt_w = 12'h000;
    chk("op", 12'(op), 12'(opcode_decoder_pkg::OP_CALL));
    chk("pc", 12'(pc), 12'(pair_target));
    chk("call_return_addr", 12'(call_return_addr), 12'(base + 10'h002));
    exp_pc = pair_target;
    issue(12'h412);
    chk("op", 12'(op), 12'(opcode_decoder_pkg::OP_RETURN));
    chk("pc", 12'(pc), 12'(return_addr));
    exp_pc = return_addr;
    exec(12'h000, opcode_decoder_pkg::OP_NOP, 1'b0);
    // A call word without its jump word behind it only steps the counter.
    issue(12'h312);
    chk("pc", 12'(pc), 12'(exp_pc + 10'h001));
    chk("call_return_addr", 12'(call_return_addr), 12'(base + 10'h002));
    chk("branch_taken", 12'(branch_taken), 12'h000);
    exp_pc = exp_pc + 10'h001;
    done_test("call");
  endtask

  task automatic t_misc;
    logic [11:0] code [11] = '{12'h31F, 12'h33F, 12'h125, 12'h131, 12'hD13, 12'h000, 12'h111, 12'hA13,
      12'hB00, 12'h431, 12'hFFF};
    opcode_decoder_pkg::op_t want [11] = '{opcode_decoder_pkg::OP_TIMER_IMM, opcode_decoder_pkg::OP_TIMER_IND,
      opcode_decoder_pkg::OP_STATUS_REG, opcode_decoder_pkg::OP_STATUS_IMM, opcode_decoder_pkg::OP_SET_CARRY,
      opcode_decoder_pkg::OP_NOP, opcode_decoder_pkg::OP_HALT, opcode_decoder_pkg::OP_INC_ACC,
      opcode_decoder_pkg::OP_NOP, opcode_decoder_pkg::OP_NOP, opcode_decoder_pkg::OP_NOP};
    for (int h = 0; h < 2; h++) begin
      exec(h == 1 ? 12'hF1F : 12'hF3F, opcode_decoder_pkg::OP_ALU, 1'b0);
      chk("src", 12'(src), 12'(opcode_decoder_pkg::SRC_TIMER));
      chk("timer_high", 12'(timer_high), 12'(h));
      exec(h == 1 ? 12'h21F : 12'h23F, opcode_decoder_pkg::OP_ACC_TO_TIMER, 1'b0);
      chk("timer_high", 12'(timer_high), 12'(h));
    end
    for (int i = 0; i < 11; i++) begin
      exec(code[i], want[i], 1'b0);
    end
    for (int s = 0; s < 2; s++) begin
      serial_sel = s[0];
      exec(12'hF13, opcode_decoder_pkg::OP_ROT_ACC, 1'b0);
      chk("rot_msb_to_lsb", 12'(rot_msb_to_lsb), 12'(!s[0]));
    end
    done_test("misc");
  endtask

  // Main sequence: reset for 16 cycles, then each scenario in turn.
  initial begin
    repeat (16) @(negedge clk);
    chk("pc", 12'(pc), 12'h000);
    chk("op_valid", 12'(op_valid), 12'h000);
    sys_rst = 1'b0;
    t_alu;
    t_port;
    t_move;
    t_branch;
    t_call;
    t_misc;
    give_verdict;
  end

  // The tests need under 130 cycles; twenty thousand means the run has hung.
  initial begin
    #2000000;
    fails++;
    give_verdict;
  end
endmodule
